// >>> core/ict_timer.sv
`timescale 1ns/1ns
module ict_timer
    import ict_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input ict_req_t req,
    input wire logic irq_pin,
    input wire logic div_resolved,
    output logic ready,
    output logic busy,
    output logic done,
    output logic idle_state,
    output logic processor_clock_output,
    output logic [5:0] base_cycle_count,
    output logic [5:0] address_cycle_count,
    output logic [4:0] base_offchip_byte_cycles,
    output logic [4:0] address_offchip_byte_cycles,
    output logic [9:0] total_cycles,
    output logic [9:0] elapsed_cycles
);

    typedef enum logic [1:0] {S_READY, S_RUN, S_WAIT_IRQ} ict_state_t;

    ict_state_t state_q;
    logic [3:0] div_cnt_q;
    logic tick;
    logic irq_s1_q, irq_s2_q, irq_s3_q, irq_q;
    ict_cost_t src_cost, dst_cost;
    logic [5:0] base_d;
    logic [4:0] base_xm_d;
    logic [9:0] total_d;
    logic [9:0] remain_q;
    ict_op_t op_q;
    logic last_tick;

    // ------------------------------------------------------------
    // processor clock divider
    // ------------------------------------------------------------
    // one tick per processor clock
    always_ff @(posedge clk)
    begin
        if (rst || div_cnt_q == ICT_PROC_DIV - 4'h1)
            div_cnt_q <= 4'h0;
        else
            div_cnt_q <= div_cnt_q + 4'h1;
    end

    assign tick = (div_cnt_q == 4'h0) && !rst;

    always_ff @(posedge clk)
    begin
        if (rst)
            processor_clock_output <= 1'b0;
        else
            processor_clock_output <= (div_cnt_q < (ICT_PROC_DIV >> 1));
    end

    // ------------------------------------------------------------
    // interrupt pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
            irq_s3_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_s1_q <= irq_pin;
            irq_s2_q <= irq_s1_q;
            irq_s3_q <= irq_s2_q;
            if (irq_s2_q == irq_s3_q)
                irq_q <= irq_s3_q;
        end
    end

    // ------------------------------------------------------------
    // cost calculation
    // ------------------------------------------------------------
    ict_addr_cost u_src_cost
    (
        .mode(req.src_mode),
        .reg_zero(req.src_reg_zero),
        .ws_off(req.ws_off),
        .base_off(req.base_off),
        .cost(src_cost)
    );

    ict_addr_cost u_dst_cost
    (
        .mode(req.dst_mode),
        .reg_zero(req.dst_reg_zero),
        .ws_off(req.ws_off),
        .base_off(req.base_off),
        .cost(dst_cost)
    );

    always_comb
    begin
        base_d = ICT_EXECUTE_BASE;
        base_xm_d = 5'h00;
        case (req.op)
            ICT_OP_SHIFT:
            begin
                if (req.count != 4'h0)
                    base_d = ICT_SHIFT_BASE + 6'(req.count);
                else if (req.wr0_low == 4'h0)
                    base_d = ICT_SHIFT_WR0_ZERO;
                else
                    base_d = ICT_SHIFT_WR0_BASE + 6'(req.wr0_low);
            end
            ICT_OP_SERIAL_STORE:
            begin
                if (req.count == 4'h0)
                    base_d = ICT_STORE_ZERO;
                else if (req.count <= ICT_STORE_LOW_MAX)
                    base_d = ICT_STORE_LOW_BASE + 6'(req.count);
                else
                    base_d = ICT_STORE_HIGH_BASE + 6'(req.count);
            end
            ICT_OP_IDLE:
                base_d = ICT_IDLE_BASE;
            ICT_OP_EXECUTE:
                base_d = ICT_EXECUTE_BASE;
            ICT_OP_DIVIDE:
                base_d = ICT_DIVIDE_WORST;
            ICT_OP_CONTEXT:
            begin
                base_d = req.vector_off ? ICT_CONTEXT_OFF : ICT_CONTEXT_ON;
                base_xm_d = req.vector_off ? ICT_CONTEXT_OFF_XM : 5'h00;
            end
            default:
                base_d = ICT_EXECUTE_BASE;
        endcase
    end

    always_comb
    begin
        total_d = 10'(base_d) + 10'(src_cost.cycles) + 10'(dst_cost.cycles)
            + 10'(req.wait_states) * (10'(base_xm_d) + 10'(src_cost.offchip) + 10'(dst_cost.offchip));
    end

    // ------------------------------------------------------------
    // captured figures
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            base_cycle_count <= '0;
            address_cycle_count <= '0;
            base_offchip_byte_cycles <= '0;
            address_offchip_byte_cycles <= '0;
            total_cycles <= '0;
            op_q <= ICT_OP_EXECUTE;
        end
        else if (start && ready)
        begin
            base_cycle_count <= base_d;
            address_cycle_count <= 6'(src_cost.cycles) + 6'(dst_cost.cycles);
            base_offchip_byte_cycles <= base_xm_d;
            address_offchip_byte_cycles <= 5'(src_cost.offchip) + 5'(dst_cost.offchip);
            total_cycles <= total_d;
            op_q <= req.op;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // the last tick ends the run; a resolved divide ends it early
    assign last_tick = tick && (remain_q == 10'h001 || (op_q == ICT_OP_DIVIDE && div_resolved));

    always_ff @(posedge clk)
    begin
        if (rst)
            state_q <= S_READY;
        else
        begin
            case (state_q)
                S_READY:
                    if (start)
                        state_q <= S_RUN;
                S_RUN:
                    if (last_tick)
                        state_q <= (op_q == ICT_OP_IDLE) ? S_WAIT_IRQ : S_READY;
                S_WAIT_IRQ:
                    if (irq_q)
                        state_q <= S_READY;
                default:
                    state_q <= S_READY;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            remain_q <= '0;
        else if (start && ready)
            remain_q <= total_d;
        else if (state_q == S_RUN && tick)
            remain_q <= remain_q - 10'h001;
    end

    // idle cycles keep counting so software sees the full 7+I figure
    always_ff @(posedge clk)
    begin
        if (rst || (start && ready))
            elapsed_cycles <= '0;
        else if ((state_q == S_RUN || state_q == S_WAIT_IRQ) && tick)
            elapsed_cycles <= elapsed_cycles + 10'h001;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            done <= 1'b0;
        else
            done <= (state_q == S_RUN && last_tick && op_q != ICT_OP_IDLE)
                || (state_q == S_WAIT_IRQ && irq_q);
    end

    assign ready = (state_q == S_READY);
    assign busy = (state_q != S_READY);
    assign idle_state = (state_q == S_WAIT_IRQ);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence take_s;
        start && ready;
    endsequence

    chk_shift_count: assert property (@(posedge clk) disable iff (rst)
        take_s and req.op == ICT_OP_SHIFT and req.count != 4'h0 |=> base_cycle_count == 6'($past(req.count)) + 6'd5)
        else $error("shift base wrong");
    chk_shift_wr0: assert property (@(posedge clk) disable iff (rst)
        take_s and req.op == ICT_OP_SHIFT and req.count == 4'h0 |=>
        base_cycle_count == (($past(req.wr0_low) == 4'h0) ? 6'd23 : 6'($past(req.wr0_low)) + 6'd7))
        else $error("shift wr0 base wrong");
    chk_store_count: assert property (@(posedge clk) disable iff (rst)
        take_s and req.op == ICT_OP_SERIAL_STORE |=> base_cycle_count ==
        (($past(req.count) == 4'h0) ? 6'd43 : ($past(req.count) <= 4'h8) ?
        6'($past(req.count)) + 6'd19 : 6'($past(req.count)) + 6'd27))
        else $error("store base wrong");
    chk_idle_hold: assert property (@(posedge clk) disable iff (rst)
        state_q == S_WAIT_IRQ && !irq_q |=> state_q == S_WAIT_IRQ)
        else $error("idle left without interrupt");
    chk_exec_base: assert property (@(posedge clk) disable iff (rst)
        take_s and req.op == ICT_OP_EXECUTE |=> base_cycle_count == 6'd2)
        else $error("execute base wrong");
    chk_run_bound: assert property (@(posedge clk) disable iff (rst)
        state_q == S_RUN |-> elapsed_cycles < total_cycles)
        else $error("run exceeds count");
    chk_context_base: assert property (@(posedge clk) disable iff (rst)
        take_s and req.op == ICT_OP_CONTEXT |=> base_cycle_count == ($past(req.vector_off) ? 6'd20 : 6'd14))
        else $error("context switch base wrong");
    chk_ind_cost: assert property (@(posedge clk) disable iff (rst)
        req.src_mode == ICT_MODE_IND |-> src_cost.cycles == (req.ws_off ? 3'd2 : 3'd1)
        && src_cost.offchip == (req.ws_off ? 3'd2 : 3'd0))
        else $error("indirect cost wrong");
    chk_auto_cost: assert property (@(posedge clk) disable iff (rst)
        req.src_mode == ICT_MODE_AUTO_INC |-> src_cost.cycles == (req.ws_off ? 3'd5 : 3'd3)
        && src_cost.offchip == (req.ws_off ? 3'd4 : 3'd0))
        else $error("auto increment cost wrong");
    chk_sym_cost: assert property (@(posedge clk) disable iff (rst)
        req.src_mode == ICT_MODE_SYM_IDX && req.src_reg_zero |-> src_cost.cycles == (req.base_off ? 3'd2 : 3'd1))
        else $error("symbolic cost wrong");
    chk_idx_cost: assert property (@(posedge clk) disable iff (rst)
        req.src_mode == ICT_MODE_SYM_IDX && !req.src_reg_zero && req.ws_off && req.base_off
        |-> src_cost.cycles == 3'd5 && src_cost.offchip == 3'd4)
        else $error("indexed cost wrong");
    chk_total_time: assert property (@(posedge clk) disable iff (rst)
        done && op_q != ICT_OP_DIVIDE && op_q != ICT_OP_IDLE |-> elapsed_cycles == total_cycles)
        else $error("total time wrong");
    chk_tick_step: assert property (@(posedge clk) disable iff (rst)
        state_q == S_RUN && tick ##1 state_q == S_RUN |-> !tick [*3] ##1 tick)
        else $error("processor clock step wrong");

endmodule : ict_timer

// >>> pkg/ict_pkg.sv
package ict_pkg;

    // ------------------------------------------------------------
    // instruction classes timed by the block
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ICT_OP_SHIFT,
        ICT_OP_SERIAL_STORE,
        ICT_OP_IDLE,
        ICT_OP_EXECUTE,
        ICT_OP_DIVIDE,
        ICT_OP_CONTEXT
    } ict_op_t;

    // ------------------------------------------------------------
    // operand addressing modes
    // ------------------------------------------------------------
    localparam logic [1:0] ICT_MODE_REG = 2'h0;
    localparam logic [1:0] ICT_MODE_IND = 2'h1;
    localparam logic [1:0] ICT_MODE_SYM_IDX = 2'h2;
    localparam logic [1:0] ICT_MODE_AUTO_INC = 2'h3;

    // ------------------------------------------------------------
    // base cycle counts
    // ------------------------------------------------------------
    localparam logic [5:0] ICT_SHIFT_BASE = 6'h05;
    localparam logic [5:0] ICT_SHIFT_WR0_ZERO = 6'h17;
    localparam logic [5:0] ICT_SHIFT_WR0_BASE = 6'h07;
    localparam logic [5:0] ICT_STORE_LOW_BASE = 6'h13;
    localparam logic [5:0] ICT_STORE_HIGH_BASE = 6'h1b;
    localparam logic [5:0] ICT_STORE_ZERO = 6'h2b;
    localparam logic [3:0] ICT_STORE_LOW_MAX = 4'h8;
    localparam logic [5:0] ICT_IDLE_BASE = 6'h07;
    localparam logic [5:0] ICT_EXECUTE_BASE = 6'h02;
    localparam logic [5:0] ICT_DIVIDE_WORST = 6'h1c;
    localparam logic [5:0] ICT_CONTEXT_ON = 6'h0e;
    localparam logic [5:0] ICT_CONTEXT_OFF = 6'h14;
    localparam logic [4:0] ICT_CONTEXT_OFF_XM = 5'h0c;

    // ------------------------------------------------------------
    // operand address derivation costs
    // ------------------------------------------------------------
    localparam logic [2:0] ICT_IND_ON = 3'h1;
    localparam logic [2:0] ICT_IND_OFF = 3'h2;
    localparam logic [2:0] ICT_IND_OFF_XM = 3'h2;
    localparam logic [2:0] ICT_AUTO_ON = 3'h3;
    localparam logic [2:0] ICT_AUTO_OFF = 3'h5;
    localparam logic [2:0] ICT_AUTO_OFF_XM = 3'h4;
    localparam logic [2:0] ICT_SYM_ON = 3'h1;
    localparam logic [2:0] ICT_SYM_OFF = 3'h2;
    localparam logic [2:0] ICT_SYM_OFF_XM = 3'h2;
    localparam logic [2:0] ICT_IDX_ON = 3'h3;
    localparam logic [2:0] ICT_IDX_BASE_OFF = 3'h4;
    localparam logic [2:0] ICT_IDX_BASE_OFF_XM = 3'h2;
    localparam logic [2:0] ICT_IDX_ALL_OFF = 3'h5;
    localparam logic [2:0] ICT_IDX_ALL_OFF_XM = 3'h4;

    // ------------------------------------------------------------
    // timing: system clock and processor clock divider
    // ------------------------------------------------------------
    localparam int ICT_SYS_CLK_PERIOD_NS = 10;
    localparam int ICT_PROC_CLK_PERIOD_NS = 40;
    localparam logic [3:0] ICT_PROC_DIV = 4'(ICT_PROC_CLK_PERIOD_NS / ICT_SYS_CLK_PERIOD_NS);
    localparam logic [9:0] ICT_WORD_MIN_CYCLES = 10'h002;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed
    {
        ict_op_t op;
        logic [3:0] count;
        logic [3:0] wr0_low;
        logic [1:0] src_mode;
        logic src_reg_zero;
        logic [1:0] dst_mode;
        logic dst_reg_zero;
        logic ws_off;
        logic base_off;
        logic vector_off;
        logic [3:0] wait_states;
    } ict_req_t;

    typedef struct packed
    {
        logic [2:0] cycles;
        logic [2:0] offchip;
    } ict_cost_t;

endpackage : ict_pkg

// >>> core/ict_addr_cost.sv
`timescale 1ns/1ns
module ict_addr_cost
    import ict_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic reg_zero,
    input wire logic ws_off,
    input wire logic base_off,
    output ict_cost_t cost
);

    always_comb
    begin
        cost = '0;
        case (mode)
            ICT_MODE_IND:
            begin
                cost.cycles = ws_off ? ICT_IND_OFF : ICT_IND_ON;
                cost.offchip = ws_off ? ICT_IND_OFF_XM : 3'h0;
            end
            ICT_MODE_AUTO_INC:
            begin
                cost.cycles = ws_off ? ICT_AUTO_OFF : ICT_AUTO_ON;
                cost.offchip = ws_off ? ICT_AUTO_OFF_XM : 3'h0;
            end
            ICT_MODE_SYM_IDX:
            begin
                if (reg_zero)
                begin
                    cost.cycles = base_off ? ICT_SYM_OFF : ICT_SYM_ON;
                    cost.offchip = base_off ? ICT_SYM_OFF_XM : 3'h0;
                end
                else if (base_off && ws_off)
                begin
                    cost.cycles = ICT_IDX_ALL_OFF;
                    cost.offchip = ICT_IDX_ALL_OFF_XM;
                end
                else if (base_off)
                begin
                    cost.cycles = ICT_IDX_BASE_OFF;
                    cost.offchip = ICT_IDX_BASE_OFF_XM;
                end
                else if (ws_off)
                begin
                    // workspace off, base on: same as base-only off
                    cost.cycles = ICT_IDX_BASE_OFF;
                    cost.offchip = ICT_IDX_BASE_OFF_XM;
                end
                else
                begin
                    cost.cycles = ICT_IDX_ON;
                end
            end
            default:
            begin
                cost = '0;
            end
        endcase
    end

endmodule : ict_addr_cost

// >>> verif/ict_far_side.sv
`timescale 1ns/1ns
module ict_far_side
    import ict_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic busy,
    input wire logic idle_state,
    input wire logic [7:0] irq_delay,
    input wire logic [7:0] div_delay,
    output logic irq_pin,
    output logic div_resolved
);
    // ------------------------------------------------------------
    // delay counter, runs while an instruction is being timed
    // ------------------------------------------------------------
    logic [7:0] wait_q;

    initial
    begin
        wait_q = 8'h00;
        irq_pin = 1'b0;
        div_resolved = 1'b0;
    end

    always @(posedge clk)
    begin
        if (rst || !busy)
            wait_q <= 8'h00;
        else if (wait_q != 8'hff)
            wait_q <= wait_q + 8'h01;
    end

    // ------------------------------------------------------------
    // request lines
    // ------------------------------------------------------------
    // the interrupt pin is asynchronous, so it moves well away from the edge;
    // a zero divide delay means the quotient never resolves early
    always @(posedge clk)
    begin
        #3;
        irq_pin = idle_state && (wait_q >= irq_delay);
        div_resolved = busy && !idle_state && (div_delay != 8'h00) && (wait_q >= div_delay);
    end
endmodule : ict_far_side

// >>> verif/instruction_cycle_timing_tb_top.sv
`timescale 1ns/1ns
module instruction_cycle_timing_tb_top
    import ict_pkg::*;
;
    typedef struct packed
    {
        logic [5:0] base;
        logic [5:0] addr;
        logic [4:0] xm_base;
        logic [4:0] xm_addr;
        logic [9:0] total;
        logic [1:0] kind;
    } ict_exp_t;

    logic clk, rst, start, irq_pin, div_resolved, ready, busy, done, idle_state, pco;
    ict_req_t req;
    logic [7:0] irq_delay, div_delay;
    logic [5:0] base_cycle_count, address_cycle_count;
    logic [4:0] base_offchip_byte_cycles, address_offchip_byte_cycles;
    logic [9:0] total_cycles, elapsed_cycles;
    logic [31:0] seed, r;
    int num_errors, checked, cyc, take_cyc, hi;
    ict_exp_t exp_q[$];
    ict_exp_t e_seen;

    ict_timer u_ict_timer (.clk(clk), .rst(rst), .start(start), .req(req), .irq_pin(irq_pin),
        .div_resolved(div_resolved), .ready(ready), .busy(busy), .done(done), .idle_state(idle_state),
        .processor_clock_output(pco), .base_cycle_count(base_cycle_count),
        .address_cycle_count(address_cycle_count), .base_offchip_byte_cycles(base_offchip_byte_cycles),
        .address_offchip_byte_cycles(address_offchip_byte_cycles), .total_cycles(total_cycles),
        .elapsed_cycles(elapsed_cycles));

    ict_far_side u_ict_far_side (.clk(clk), .rst(rst), .busy(busy), .idle_state(idle_state),
        .irq_delay(irq_delay), .div_delay(div_delay), .irq_pin(irq_pin), .div_resolved(div_resolved));

    always #5 clk = ~clk;

    always @(posedge clk)
        cyc <= cyc + 1;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    function automatic ict_req_t mk(input ict_op_t op, input logic [3:0] cnt, input logic [3:0] wr0,
        input logic [1:0] m, input logic [3:0] flags, input logic [3:0] w);
        ict_req_t q;
        q = '0;
        q.op = op;
        q.count = cnt;
        q.wr0_low = wr0;
        q.src_mode = m;
        q.dst_mode = ICT_MODE_REG;
        {q.src_reg_zero, q.ws_off, q.base_off, q.vector_off} = flags;
        q.wait_states = w;
        return q;
    endfunction : mk

    // per-operand address cost, worked out independently of the design
    function automatic void mode_cost(input logic [1:0] m, input logic rz, input logic ws, input logic bo,
        output int c, output int x);
        {c, x} = {32'h0, 32'h0};
        case (m)
            ICT_MODE_IND: {c, x} = ws ? {32'h2, 32'h2} : {32'h1, 32'h0};
            ICT_MODE_AUTO_INC: {c, x} = ws ? {32'h5, 32'h4} : {32'h3, 32'h0};
            ICT_MODE_SYM_IDX:
                if (rz)
                    {c, x} = bo ? {32'h2, 32'h2} : {32'h1, 32'h0};
                else if (ws && bo)
                    {c, x} = {32'h5, 32'h4};
                else if (ws || bo)
                    {c, x} = {32'h4, 32'h2};
                else
                    {c, x} = {32'h3, 32'h0};
            default: ;
        endcase
    endfunction : mode_cost

    function automatic ict_exp_t exp_of(input ict_req_t q);
        ict_exp_t e;
        int b, xb, a, xa, c, x;
        {b, xb, a, xa} = '0;
        e = '0;
        case (q.op)
            ICT_OP_SHIFT: b = (q.count != 0) ? 32'h5 + q.count : ((q.wr0_low == 0) ? 32'h17 : 32'h7 + q.wr0_low);
            ICT_OP_SERIAL_STORE: b = (q.count == 0) ? 32'h2b : ((q.count <= 8) ? 32'h13 + q.count : 32'h1b + q.count);
            ICT_OP_IDLE: {b, e.kind} = {32'h7, 2'h2};
            ICT_OP_EXECUTE: b = 32'h2;
            ICT_OP_DIVIDE: {b, e.kind} = {32'h1c, 2'h1};
            ICT_OP_CONTEXT: {b, xb} = q.vector_off ? {32'h14, 32'h0c} : {32'h0e, 32'h0};
            default: ;
        endcase
        mode_cost(q.src_mode, q.src_reg_zero, q.ws_off, q.base_off, c, x);
        {a, xa} = {c, x};
        mode_cost(q.dst_mode, q.dst_reg_zero, q.ws_off, q.base_off, c, x);
        a += c;
        xa += x;
        e.base = 6'(b);
        e.addr = 6'(a);
        e.xm_base = 5'(xb);
        e.xm_addr = 5'(xa);
        e.total = 10'(b + a + q.wait_states * (xb + xa));
        return e;
    endfunction : exp_of

    // ------------------------------------------------------------
    // driver: times one instruction, optionally pokes start while busy
    // ------------------------------------------------------------
    task automatic run_op(input ict_req_t q, input bit poke);
        ict_exp_t e;
        int n;
        e = exp_of(q);
        n = 0;
        while (ready !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        req = q;
        start = 1'b1;
        @(posedge clk);
        #1;
        take_cyc = cyc - 1;
        exp_q.push_back(e);
        start = 1'b0;
        if (poke)
        begin
            repeat (3) @(posedge clk);
            #1;
            req = mk(ICT_OP_EXECUTE, 4'h0, 4'h0, ICT_MODE_REG, 4'h0, 4'h0);
            start = 1'b1;
            @(posedge clk);
            #1;
            start = 1'b0;
            check("total_cycles while busy", total_cycles, e.total);
        end
        if (q.op == ICT_OP_IDLE)
        begin
            repeat (40) @(posedge clk);
            #1;
            check("idle_state", idle_state, 1'b1);
            check("busy in idle", busy, 1'b1);
        end
        while (busy !== 1'b0 && n < 2000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("completion in time", n < 2000, 1'b1);
    endtask : run_op

    // ------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (done === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                check("done without request", 1'b1, 1'b0);
            end
            else
            begin
                e_seen = exp_q.pop_front();
                check("base_cycle_count", base_cycle_count, e_seen.base);
                check("address_cycle_count", address_cycle_count, e_seen.addr);
                check("base_offchip_byte_cycles", base_offchip_byte_cycles, e_seen.xm_base);
                check("address_offchip_byte_cycles", address_offchip_byte_cycles, e_seen.xm_addr);
                if (e_seen.kind != 2'h2)
                begin
                    check("total_cycles", total_cycles, e_seen.total);
                    check("latency bound", cyc - take_cyc <= 4 * e_seen.total + 5, 1'b1);
                end
                if (e_seen.kind == 2'h0)
                    check("elapsed_cycles", elapsed_cycles, e_seen.total);
                if (e_seen.kind == 2'h1)
                    check("divide bounded", elapsed_cycles <= e_seen.total, 1'b1);
            end
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        start = 1'b0;
        req = '0;
        irq_delay = 8'hff;
        div_delay = 8'h00;
        {num_errors, checked, cyc, take_cyc} = '0;
        seed = 32'h3c6e;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        check("ready after reset", ready, 1'b1);
        check("busy after reset", busy, 1'b0);
        check("total after reset", total_cycles, 10'h000);
        hi = 0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            hi += int'(pco === 1'b1);
        end
        check("processor clock duty", hi, 4);
        // shift: nonzero counts, then count zero with register zero low bits 0, 1 and 15
        r = next_rand();
        run_op(mk(ICT_OP_SHIFT, 4'h1, 4'h9, ICT_MODE_REG, 4'h0, r[3:0]), 1'b0);
        run_op(mk(ICT_OP_SHIFT, 4'hf, 4'h3, ICT_MODE_REG, 4'h0, r[7:4]), 1'b0);
        for (int i = 0; i < 3; i++)
            run_op(mk(ICT_OP_SHIFT, 4'h0, (i == 0) ? 4'h0 : ((i == 1) ? 4'h1 : 4'hf), ICT_MODE_REG, 4'h0, 4'h0), 1'b0);
        // serial store at every group boundary
        for (int i = 0; i < 5; i++)
            run_op(mk(ICT_OP_SERIAL_STORE, 4'((i * 8 + 1) >> 1 == 0 ? 0 : (i == 1 ? 1 : (i == 2 ? 8 : (i == 3 ? 9 : 15)))),
                4'h0, ICT_MODE_REG, 4'h0, 4'h0), 1'b0);
        // start while busy must be ignored
        run_op(mk(ICT_OP_SERIAL_STORE, 4'hf, 4'h0, ICT_MODE_REG, 4'h0, 4'h0), 1'b1);
        // every addressing mode and location combination, random wait states
        for (int i = 0; i < 32; i++)
        begin
            r = next_rand();
            run_op(mk(ICT_OP_EXECUTE, 4'h0, 4'h0, 2'(i >> 3), {3'(i), 1'b0}, r[3:0]), 1'b0);
        end
        // context switch with vectors on and off chip
        for (int i = 0; i < 2; i++)
        begin
            r = next_rand();
            run_op(mk(ICT_OP_CONTEXT, 4'h0, 4'h0, ICT_MODE_REG, {3'h0, 1'(i)}, r[3:0]), 1'b0);
        end
        // divide: quotient resolves early, then runs the worst case
        r = next_rand();
        div_delay = 8'h14 + {3'h0, r[4:0]};
        run_op(mk(ICT_OP_DIVIDE, 4'h0, 4'h0, ICT_MODE_REG, 4'h0, 4'h0), 1'b0);
        div_delay = 8'h00;
        run_op(mk(ICT_OP_DIVIDE, 4'h0, 4'h0, ICT_MODE_REG, 4'h0, 4'h0), 1'b0);
        // idle waits for the interrupt
        r = next_rand();
        irq_delay = 8'h3c + {2'h0, r[5:0]};
        run_op(mk(ICT_OP_IDLE, 4'h0, 4'h0, ICT_MODE_REG, 4'h0, 4'h0), 1'b0);
        irq_delay = 8'hff;
        repeat (4) @(posedge clk);
        check("pending results", exp_q.size(), 0);
        report_and_stop();
    end

    initial
    begin
        // more than five times the longest possible run of all scenarios
        #300000;
        num_errors++;
        report_and_stop();
    end
endmodule : instruction_cycle_timing_tb_top
